// file: core/msp_pkg.sv
package msp_pkg;
  // ************************************************************
  // word format and buffer geometry
  // ************************************************************
  localparam int SHIFT_W       = 16;
  localparam int LEN_W         = 5;
  localparam int MIN_LEN       = 2;
  localparam int MAX_LEN       = 16;
  localparam int BUF_ENTRIES   = 256;
  localparam int IDX_W         = 8;
  localparam int FIELD_W       = 16;
  localparam int NUM_GROUPS    = 4;
  localparam int GRP_W         = 2;
  localparam int PS_W          = 8;
  localparam int DLY_W         = 8;
  localparam int GPIO_W        = 4;
  // ************************************************************
  // per-word control field layout
  // ************************************************************
  localparam int CTL_LEN_LSB   = 0;
  localparam int CTL_POL_BIT   = 5;
  localparam int CTL_PHA_BIT   = 6;
  localparam int CTL_HOLD_BIT  = 7;
  localparam int CTL_PS_LSB    = 8;
  // ************************************************************
  // status field layout and reset values
  // ************************************************************
  localparam logic [FIELD_W-1:0] STAT_DONE     = 16'h0001;
  localparam logic [FIELD_W-1:0] FIELD_RESET   = 16'h0000;
  // ************************************************************
  // chip select timing counts in bus clock cycles
  // ************************************************************
  localparam logic [DLY_W:0] CS_SETUP_ADD      = 9'h002;
  localparam logic [DLY_W:0] CS_SETUP_HOLD_ADD = 9'h003;
  localparam logic [DLY_W:0] CS_RELEASE_ADD    = 9'h001;

  typedef struct packed {
    logic [PS_W-1:0]  prescale;
    logic             hold;
    logic             phase;
    logic             polarity;
    logic [LEN_W-1:0] length;
  } msp_fmt_s;

  typedef struct packed {
    logic [IDX_W-1:0] first;
    logic [IDX_W-1:0] last;
  } msp_group_s;

  typedef struct packed {
    logic             we;
    logic [IDX_W-1:0] idx;
    logic [1:0]       field;
    logic [FIELD_W-1:0] data;
  } msp_mem_req_s;

  localparam logic [1:0] FLD_TX   = 2'h0;
  localparam logic [1:0] FLD_RX   = 2'h1;
  localparam logic [1:0] FLD_CTL  = 2'h2;
  localparam logic [1:0] FLD_STAT = 2'h3;
endpackage

// file: core/msp_baud.sv
`timescale 1ns/100ps
`default_nettype none
module msp_baud
  import msp_pkg::*;
(
  input  wire logic            clk,
  input  wire logic            rst,
  input  wire logic            run,
  input  wire logic [PS_W-1:0] prescale,
  output logic                 half_tick
);
  // ************************************************************
  // half period counter
  // ************************************************************
  logic [PS_W:0] cnt_reg;
  logic [PS_W:0] half_len;
  logic [PS_W:0] period;

  // zero prescale still yields a two cycle period
  always_comb
  begin
    period = (prescale == '0) ? 9'h002 : ({1'b0, prescale} + 9'h001);
    half_len = period >> 1;
    if (half_len == '0)
    begin
      half_len = 9'h001;
    end
  end

  // tick is not registered, so the first half period is as long as the rest
  assign half_tick = run && (cnt_reg + 9'h001 >= half_len);

  always_ff @(posedge clk)
  begin
    if (rst || !run)
    begin
      cnt_reg <= '0;
    end
    else if (half_tick)
    begin
      cnt_reg <= '0;
    end
    else
    begin
      cnt_reg <= cnt_reg + 9'h001;
    end
  end
endmodule
`default_nettype wire

// file: core/msp_core.sv
// Function
// - words of 2 to 16 bits shift through a 16-bit shift register
// - master clock comes from an 8-bit divider, period at most 256 cycles
// - master drives the serial clock pin itself
// - each word carries its own length, clocking and prescale format
// - clock and data pins act as general-purpose outputs when disabled, slave out also in master mode, gpio_in reads back gpio_out
// - buffer memory holds 256 entries
// - each entry holds transmit, receive, control and status fields
// - memory splits into groups of consecutive entries
// - chip select leads first clock edge by delay plus 2, or 3 with hold
// - chip select trails last edge by half period plus delay plus 1, or 2 with hold
// - master clock high and low phases are equal halves
// - phase 0 master samples input on falling edge, rising if polarity 1
// - phase 0 master output changes half period before slave sampling edge
// - clock period is prescale plus one for odd prescale, prescale when even, two when prescale is zero
`timescale 1ns/100ps
`default_nettype none
module msp_core
  import msp_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire logic                 enable,
  input  wire logic                 master_mode,
  input  wire logic [DLY_W-1:0]     cs_to_clock_delay,
  input  wire logic [DLY_W-1:0]     clock_to_cs_delay,
  input  wire msp_group_s [NUM_GROUPS-1:0] groups,
  input  wire logic [GRP_W-1:0]     group_sel,
  input  wire logic                 group_start,
  input  wire msp_mem_req_s         mem_req,
  output logic [FIELD_W-1:0]        mem_rdata,
  output logic                      busy,
  output logic                      group_done,
  input  wire logic                 serial_clock_in,
  output logic                      serial_clock_out,
  output logic                      serial_clock_oe,
  input  wire logic                 master_in_in,
  input  wire logic                 slave_in_in,
  output logic                      master_out_pin,
  output logic                      master_out_oe,
  output logic                      slave_out_pin,
  output logic                      slave_out_oe,
  input  wire logic                 cs_in,
  output logic                      cs_out_n,
  output logic                      cs_oe,
  input  wire logic [GPIO_W-1:0]    gpio_out,
  input  wire logic [GPIO_W-1:0]    gpio_dir,
  output logic [GPIO_W-1:0]         gpio_in
);
  // ************************************************************
  // buffer memory
  // ************************************************************
  logic [FIELD_W-1:0] tx_mem   [BUF_ENTRIES];
  logic [FIELD_W-1:0] rx_mem   [BUF_ENTRIES];
  logic [FIELD_W-1:0] ctl_mem  [BUF_ENTRIES];
  logic [FIELD_W-1:0] stat_mem [BUF_ENTRIES];

  typedef enum {ST_IDLE, ST_LOAD, ST_SETUP, ST_SHIFT, ST_TAIL, ST_GAP,
                ST_SLAVE} msp_state_e;
  msp_state_e state_reg;

  logic [IDX_W-1:0]   idx_reg;
  logic [IDX_W-1:0]   last_reg;
  logic [SHIFT_W-1:0] shift_reg;
  logic [LEN_W-1:0]   bits_reg;
  msp_fmt_s           fmt_reg;
  logic [DLY_W:0]     dly_reg;
  logic               sclk_reg;
  logic               edge_half_reg;
  logic               done_we;
  logic [SHIFT_W-1:0] done_data;
  logic               half_tick;
  logic               run;
  logic [LEN_W-1:0]   len_clip;
  msp_fmt_s           fmt_word;
  logic [LEN_W-1:0]   lead_cnt_reg;
  logic [LEN_W-1:0]   tx_pos;
  logic               tx_bit;
  logic               out_bit_reg;
  logic [2:0]         samp_pipe_reg;
  logic [PS_W:0]      half_cyc;

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  logic [3:0] s1_reg;
  logic [3:0] s2_reg;
  logic [GPIO_W-1:0] g1_reg;
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s1_reg <= '0;
      s2_reg <= '0;
      g1_reg <= '0;
      gpio_in <= '0;
    end
    else
    begin
      s1_reg <= {cs_in, slave_in_in, master_in_in, serial_clock_in};
      s2_reg <= s1_reg;
      g1_reg <= gpio_out;
      gpio_in <= g1_reg;
    end
  end
  logic sck_s, miso_s, mosi_s, csi_s, sck_d_reg;
  assign sck_s  = s2_reg[0];
  assign miso_s = s2_reg[1];
  assign mosi_s = s2_reg[2];
  assign csi_s  = s2_reg[3];

  // ************************************************************
  // format decode
  // ************************************************************
  assign fmt_word = msp_fmt_s'(ctl_mem[idx_reg]);
  always_comb
  begin
    len_clip = fmt_reg.length;
    if (len_clip < LEN_W'(MIN_LEN) || len_clip > LEN_W'(MAX_LEN))
    begin
      len_clip = LEN_W'(MAX_LEN);
    end
  end

  assign tx_pos = len_clip - LEN_W'(1) - lead_cnt_reg;
  assign tx_bit = tx_mem[idx_reg][tx_pos[3:0]];
  assign half_cyc = (fmt_reg.prescale == '0) ? 9'h001
                  : (({1'b0, fmt_reg.prescale} + 9'h001) >> 1);
  assign run = (state_reg == ST_SHIFT) || (state_reg == ST_TAIL);
  msp_baud u_baud
  (
    .clk      (clk),
    .rst      (rst),
    .run      (run),
    .prescale (fmt_reg.prescale),
    .half_tick(half_tick)
  );

  // ************************************************************
  // transfer sequencer
  // ************************************************************
  always_ff @(posedge clk)
  begin
    done_we <= 1'b0;
    group_done <= 1'b0;
    if (rst || !enable)
    begin
      state_reg     <= ST_IDLE;
      idx_reg       <= '0;
      last_reg      <= '0;
      shift_reg     <= '0;
      bits_reg      <= '0;
      fmt_reg       <= '0;
      dly_reg       <= '0;
      sclk_reg      <= 1'b0;
      edge_half_reg <= 1'b0;
      done_data     <= '0;
      busy          <= 1'b0;
      cs_out_n      <= 1'b1;
      sck_d_reg     <= 1'b0;
      lead_cnt_reg  <= '0;
      out_bit_reg   <= 1'b0;
      samp_pipe_reg <= '0;
    end
    else
    begin
      sck_d_reg <= sck_s;
      // input sampled three cycles late to cover the pin synchroniser
      samp_pipe_reg <= {samp_pipe_reg[1:0], 1'b0};
      if (samp_pipe_reg[2])
      begin
        shift_reg <= {shift_reg[SHIFT_W-2:0], miso_s};
        bits_reg  <= bits_reg + LEN_W'(1);
      end
      unique case (state_reg)
        ST_IDLE:
        begin
          sclk_reg <= fmt_reg.polarity;
          if (group_start)
          begin
            idx_reg  <= groups[group_sel].first;
            last_reg <= groups[group_sel].last;
            busy     <= 1'b1;
            state_reg <= master_mode ? ST_LOAD : ST_SLAVE;
          end
        end
        ST_LOAD:
        begin
          fmt_reg   <= fmt_word;
          shift_reg <= '0;
          bits_reg  <= '0;
          lead_cnt_reg <= '0;
          cs_out_n  <= 1'b0;
          // one cycle spent here, so remaining setup is delay plus 1 or 2
          dly_reg   <= {1'b0, cs_to_clock_delay} +
                       (fmt_word.hold ? CS_SETUP_HOLD_ADD : CS_SETUP_ADD)
                       - 9'h001;
          sclk_reg  <= fmt_word.polarity;
          edge_half_reg <= 1'b0;
          state_reg <= ST_SETUP;
        end
        ST_SETUP:
        begin
          if (dly_reg <= 9'h001)
          begin
            // first leading edge closes the setup window
            sclk_reg      <= ~sclk_reg;
            edge_half_reg <= 1'b1;
            out_bit_reg   <= tx_bit;
            lead_cnt_reg  <= LEN_W'(1);
            state_reg     <= ST_SHIFT;
          end
          else
          begin
            dly_reg <= dly_reg - 9'h001;
          end
        end
        ST_SHIFT:
        begin
          if (half_tick)
          begin
            sclk_reg      <= ~sclk_reg;
            edge_half_reg <= ~edge_half_reg;
            if (!edge_half_reg)
            begin
              // leading edge: next output bit
              out_bit_reg  <= tx_bit;
              lead_cnt_reg <= lead_cnt_reg + LEN_W'(1);
            end
            else
            begin
              // trailing edge: input sampled
              samp_pipe_reg <= {samp_pipe_reg[1:0], 1'b1};
              if (lead_cnt_reg == len_clip)
              begin
                state_reg <= ST_TAIL;
                // extra cycle offsets the clock pin register
                dly_reg   <= {1'b0, clock_to_cs_delay} + CS_RELEASE_ADD
                             + half_cyc + 9'h001;
              end
            end
          end
        end
        ST_TAIL:
        begin
          // half period still to run after the trailing edge
          if (dly_reg <= 9'h001)
          begin
            done_we   <= 1'b1;
            done_data <= samp_pipe_reg[2]
                         ? {shift_reg[SHIFT_W-2:0], miso_s} : shift_reg;
            if (!fmt_reg.hold)
            begin
              cs_out_n <= 1'b1;
            end
            state_reg <= ST_GAP;
          end
          else
          begin
            dly_reg <= dly_reg - 9'h001;
          end
        end
        ST_GAP:
        begin
          if (idx_reg == last_reg)
          begin
            cs_out_n   <= 1'b1;
            busy       <= 1'b0;
            group_done <= 1'b1;
            state_reg  <= ST_IDLE;
          end
          else
          begin
            idx_reg   <= idx_reg + IDX_W'(1);
            state_reg <= ST_LOAD;
          end
        end
        ST_SLAVE:
        begin
          // slave shifts only on the external clock
          if (csi_s)
          begin
            bits_reg <= '0;
            fmt_reg  <= fmt_word;
            shift_reg <= tx_mem[idx_reg];
          end
          else if (sck_s != sck_d_reg && sck_s != fmt_reg.polarity)
          begin
            shift_reg <= {shift_reg[SHIFT_W-2:0], mosi_s};
            bits_reg  <= bits_reg + LEN_W'(1);
          end
          else if (bits_reg == len_clip)
          begin
            done_we   <= 1'b1;
            done_data <= shift_reg;
            bits_reg  <= '0;
            if (idx_reg == last_reg)
            begin
              busy <= 1'b0;
              group_done <= 1'b1;
              state_reg <= ST_IDLE;
            end
            else
            begin
              idx_reg <= idx_reg + IDX_W'(1);
              fmt_reg <= msp_fmt_s'(ctl_mem[idx_reg + IDX_W'(1)]);
              shift_reg <= tx_mem[idx_reg + IDX_W'(1)];
            end
          end
        end
      endcase
    end
  end

  // ************************************************************
  // memory port, hardware completion wins over software
  // ************************************************************
  always_ff @(posedge clk)
  begin
    if (mem_req.we)
    begin
      unique case (mem_req.field)
        FLD_TX:   tx_mem[mem_req.idx]   <= mem_req.data;
        FLD_RX:   rx_mem[mem_req.idx]   <= mem_req.data;
        FLD_CTL:  ctl_mem[mem_req.idx]  <= mem_req.data;
        FLD_STAT: stat_mem[mem_req.idx] <= mem_req.data;
      endcase
    end
    if (done_we)
    begin
      rx_mem[idx_reg]   <= done_data;
      stat_mem[idx_reg] <= STAT_DONE;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      mem_rdata <= FIELD_RESET;
    end
    else
    begin
      unique case (mem_req.field)
        FLD_TX:   mem_rdata <= tx_mem[mem_req.idx];
        FLD_RX:   mem_rdata <= rx_mem[mem_req.idx];
        FLD_CTL:  mem_rdata <= ctl_mem[mem_req.idx];
        FLD_STAT: mem_rdata <= stat_mem[mem_req.idx];
      endcase
    end
  end

  // ************************************************************
  // pin drivers
  // ************************************************************
  logic [SHIFT_W-1:0] out_word;
  // msb of the active length leads, so shorter words stay right aligned
  assign out_word = shift_reg << (LEN_W'(MAX_LEN) - len_clip);
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      serial_clock_out <= 1'b0;
      serial_clock_oe  <= 1'b0;
      master_out_pin   <= 1'b0;
      master_out_oe    <= 1'b0;
      slave_out_pin    <= 1'b0;
      slave_out_oe     <= 1'b0;
      cs_oe            <= 1'b0;
    end
    else if (!enable)
    begin
      // disabled port leaves clock and data pins to general use, chip select only its direction
      serial_clock_out <= gpio_out[0];
      serial_clock_oe  <= gpio_dir[0];
      master_out_pin   <= gpio_out[1];
      master_out_oe    <= gpio_dir[1];
      slave_out_pin    <= gpio_out[2];
      slave_out_oe     <= gpio_dir[2];
      cs_oe            <= gpio_dir[3];
    end
    else
    begin
      // slave pins it listens on are inputs, never driven
      serial_clock_out <= master_mode ? sclk_reg : 1'b0;
      serial_clock_oe  <= master_mode;
      // bit stands from leading edge, half period before sampling edge
      master_out_pin   <= master_mode ? out_bit_reg : 1'b0;
      master_out_oe    <= master_mode;
      slave_out_pin    <= master_mode ? gpio_out[2] : out_word[SHIFT_W-1];
      slave_out_oe     <= master_mode ? gpio_dir[2] : ~csi_s;
      cs_oe            <= master_mode;
    end
  end
endmodule
`default_nettype wire

// file: dv/msp_core_properties.sv
`timescale 1ns/100ps
`default_nettype none
// ********
// checker
// ********
module msp_core_properties
  import msp_pkg::*;
(
  input wire logic              clk,
  input wire logic              rst,
  input wire logic              enable,
  input wire logic              master_mode,
  input wire logic [DLY_W-1:0]  cs_to_clock_delay,
  input wire logic [DLY_W-1:0]  clock_to_cs_delay,
  input wire logic              busy,
  input wire logic              group_done,
  input wire logic              serial_clock_out,
  input wire logic              serial_clock_oe,
  input wire logic              cs_out_n,
  input wire logic [GPIO_W-1:0] gpio_out,
  input wire logic [GPIO_W-1:0] gpio_in
);
  logic       sck_reg;
  logic       arm_reg;
  logic [9:0] hcnt_reg;
  logic [9:0] scnt_reg;
  wire logic  tgl = serial_clock_out != sck_reg;
  wire logic [9:0] c2t = {2'h0, cs_to_clock_delay};
  wire logic [9:0] t2c = {2'h0, clock_to_cs_delay};
  always_ff @(posedge clk)
  begin
    sck_reg <= serial_clock_out;
    if (tgl) hcnt_reg <= 10'h000;
    else if (hcnt_reg != 10'h3FF) hcnt_reg <= hcnt_reg + 10'h001;
  end
  // early moves to a new idle level must not end the setup window
  always_ff @(posedge clk)
  begin
    if (cs_out_n) arm_reg <= 1'b1;
    else if (tgl && scnt_reg > 10'h001) arm_reg <= 1'b0;
    if (cs_out_n) scnt_reg <= 10'h000;
    else if (arm_reg) scnt_reg <= scnt_reg + 10'h001;
  end
  default clocking dcb @(posedge clk);
  endclocking
  default disable iff (rst);
  reset_idle_a: assert property (disable iff (1'b0) rst |=> cs_out_n && !busy)
    else $error("port not idle after reset");
  disabled_quiet_a: assert property (!enable && !busy |-> cs_out_n)
    else $error("select active while disabled");
  clock_drive_a: assert property (master_mode && !cs_out_n |-> serial_clock_oe)
    else $error("master not driving serial clock");
  slave_quiet_a: assert property ((enable && !master_mode) [*3] |-> !serial_clock_oe)
    else $error("slave drives serial clock");
  setup_time_a: assert property (master_mode && arm_reg && !cs_out_n && tgl
    && scnt_reg > 10'h001 |-> scnt_reg >= c2t + 10'h001 && scnt_reg <= c2t + 10'h004)
    else $error("select to clock setup wrong");
  tail_time_a: assert property (master_mode && $rose(cs_out_n)
    |-> hcnt_reg >= t2c && hcnt_reg <= t2c + 10'h084)
    else $error("clock to select hold wrong");
  gpio_loop_a: assert property (!$past(rst) && !$past(rst, 2)
    |-> gpio_in == $past(gpio_out, 2))
    else $error("general purpose loopback wrong");
  done_idle_a: assert property (group_done |-> ##[0:1] !busy)
    else $error("busy after group done");
  done_pulse_a: assert property (group_done |=> !group_done)
    else $error("group done not a pulse");
  cover property (group_done);
  cover property ($fell(cs_out_n));
  cover property (!master_mode [*3]);
endmodule
bind msp_core msp_core_properties msp_core_properties_inst (
  .clk(clk), .rst(rst), .enable(enable), .master_mode(master_mode),
  .cs_to_clock_delay(cs_to_clock_delay),
  .clock_to_cs_delay(clock_to_cs_delay), .busy(busy),
  .group_done(group_done), .serial_clock_out(serial_clock_out),
  .serial_clock_oe(serial_clock_oe), .cs_out_n(cs_out_n),
  .gpio_out(gpio_out), .gpio_in(gpio_in));
`default_nettype wire

// file: dv/msp_slave_model.sv
`timescale 1ns/100ps
`default_nettype none
// ********
// external slave
// ********
module msp_slave_model
#(parameter logic [15:0] REPLY = 16'hA5C3)
(
  input wire logic   clk,
  input wire logic   sck,
  input wire logic   cs_n,
  input wire logic   mosi,
  input wire logic   pol,
  output logic       miso,
  output logic [15:0] rx_word,
  output logic [9:0] act_len,
  output logic [9:0] idle_len
);
  logic [3:0] idx;
  logic       prev_reg, run_reg, junk_reg;
  logic [9:0] cnt_reg;
  // released line keeps moving so a stale bit never passes
  assign miso = cs_n ? junk_reg : REPLY[idx];
  always @(negedge cs_n) idx = 4'h0;
  always @(sck)
  begin
    if (!cs_n && sck != pol) idx = idx - 4'h1;
    if (!cs_n && sck == pol) rx_word = {rx_word[14:0], mosi};
  end
  always_ff @(posedge clk)
  begin
    prev_reg <= sck;
    junk_reg <= junk_reg !== 1'b1;
    if (sck != prev_reg) cnt_reg <= 10'h000;
    else cnt_reg <= cnt_reg + 10'h001;
    if (sck != prev_reg && sck == pol) act_len <= cnt_reg;
    if (sck != prev_reg && sck != pol && run_reg) idle_len <= cnt_reg;
    run_reg <= !cs_n && (run_reg || (sck != prev_reg && sck == pol));
  end
endmodule
`default_nettype wire

// file: dv/msp_core_tb.sv
`timescale 1ns/100ps
`default_nettype none
// ********
// bench
// ********
module msp_core_tb;
  import msp_pkg::*;
  logic clk, rst, enable, master_mode, group_start, pol;
  logic busy, group_done, sck_out, sck_oe, miso, mosi, mosi_oe, cs_n, cs_oe;
  logic [DLY_W-1:0] c2t, t2c;
  logic [GRP_W-1:0] group_sel;
  logic [GPIO_W-1:0] gpio_out, gpio_dir, gpio_in;
  logic [FIELD_W-1:0] mem_rdata, rd, m, e;
  logic [15:0] srx;
  logic [9:0] act_len, idle_len;
  msp_group_s [NUM_GROUPS-1:0] groups;
  msp_mem_req_s mem_req;
  int bad_count, comparisons, rises;
  // rows: length, polarity, prescale, transmit word, expected receive word
  logic [4:0] r_len [5] = '{5'h10, 5'h02, 5'h08, 5'h0D, 5'h10};
  logic r_pol [5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
  logic [7:0] r_ps [5] = '{8'h00, 8'h01, 8'h03, 8'h00, 8'hFF};
  logic [15:0] r_tx [5] = '{16'h1234, 16'h0002, 16'h00A7, 16'h1B6D, 16'hF00F};
  logic [15:0] r_rx [5] = '{16'hA5C3, 16'h0002, 16'h00A5, 16'h14B8, 16'hA5C3};
  logic [4:0] h_len [3] = '{5'h04, 5'h09, 5'h10};
  logic [15:0] h_rx [3] = '{16'h000A, 16'h00B8, 16'h74B8};
  msp_core msp_core_inst (.clk(clk), .rst(rst), .enable(enable),
    .master_mode(master_mode), .cs_to_clock_delay(c2t),
    .clock_to_cs_delay(t2c), .groups(groups), .group_sel(group_sel),
    .group_start(group_start), .mem_req(mem_req), .mem_rdata(mem_rdata),
    .busy(busy), .group_done(group_done), .serial_clock_in(1'b0),
    .serial_clock_out(sck_out), .serial_clock_oe(sck_oe),
    .master_in_in(miso), .slave_in_in(1'b0), .master_out_pin(mosi),
    .master_out_oe(mosi_oe), .slave_out_pin(), .slave_out_oe(),
    .cs_in(1'b1), .cs_out_n(cs_n), .cs_oe(cs_oe), .gpio_out(gpio_out),
    .gpio_dir(gpio_dir), .gpio_in(gpio_in));
  msp_slave_model msp_slave_model_inst (.clk(clk), .sck(sck_out),
    .cs_n(cs_n), .mosi(mosi), .pol(pol), .miso(miso), .rx_word(srx),
    .act_len(act_len), .idle_len(idle_len));
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic wr(input logic [7:0] i, input logic [1:0] f,
                    input logic [15:0] d);
    @(posedge clk) mem_req <= '{1'b1, i, f, d};
    @(posedge clk) mem_req.we <= 1'b0;
  endtask
  task automatic rdf(input logic [7:0] i, input logic [1:0] f);
    @(posedge clk) mem_req <= '{1'b0, i, f, 16'h0000};
    repeat (2) @(posedge clk);
    #1 rd = mem_rdata;
  endtask
  // second start while busy must be ignored
  task automatic run(input logic [1:0] g, input logic again);
    logic pc;
    @(posedge clk);
    group_sel <= g;
    group_start <= 1'b1;
    @(posedge clk) group_start <= 1'b0;
    if (again)
    begin
      repeat (5) @(posedge clk);
      group_start <= 1'b1;
      @(posedge clk) group_start <= 1'b0;
    end
    rises = 0;
    pc = 1'b1;
    for (int n = 0; n <= 20000; n++)
    begin
      @(negedge clk);
      if (cs_n === 1'b1 && pc === 1'b0) rises++;
      pc = cs_n;
      if (group_done === 1'b1) break;
      if (n == 20000)
      begin
        bad_count++;
        final_report();
      end
    end
  endtask
  initial
  begin
    rst = 1'b1; enable = 1'b0; master_mode = 1'b1; group_start = 1'b0;
    pol = 1'b0; c2t = 8'h03; t2c = 8'h05; group_sel = 2'h0;
    gpio_out = 4'h0; gpio_dir = 4'h0; mem_req = '0; groups = '0;
    bad_count = 0; comparisons = 0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    check({13'h0, cs_n, busy, sck_out}, 16'h0004);
    rdf(8'h00, FLD_STAT);
    check(rd, FIELD_RESET);
    wr(8'hFF, FLD_TX, 16'h5AA5);
    rdf(8'hFF, FLD_TX);
    check(rd, 16'h5AA5);
    @(posedge clk) group_start <= 1'b1;
    @(posedge clk) group_start <= 1'b0;
    repeat (4) @(negedge clk);
    check({14'h0, busy, cs_n}, 16'h0001);
    enable <= 1'b1;
    for (int i = 0; i < 5; i++)
    begin
      pol = r_pol[i];
      wr(i[7:0], FLD_TX, r_tx[i]);
      wr(i[7:0], FLD_CTL, {r_ps[i], 2'h0, r_pol[i], r_len[i]});
      groups[0] <= '{i[7:0], i[7:0]};
      run(2'h0, 1'b0);
      check(rises[15:0], 16'h0001);
      rdf(i[7:0], FLD_RX);
      check(rd, r_rx[i]);
      rdf(i[7:0], FLD_STAT);
      check(rd, STAT_DONE);
      m = (16'h0001 << r_len[i]) - 16'h0001;
      check(srx & m, r_tx[i] & m);
      e = (r_ps[i] == 8'h00) ? 16'h0000
        : ({8'h00, r_ps[i]} + 16'h0001) / 16'h0002 - 16'h0001;
      check({6'h0, act_len}, e);
      check({6'h0, idle_len}, e);
    end
    pol = 1'b0;
    c2t <= 8'h00;
    t2c <= 8'h00;
    for (int k = 0; k < 3; k++)
    begin
      wr(8'd20 + k[7:0], FLD_TX, 16'hC3C3);
      wr(8'd20 + k[7:0], FLD_CTL, {8'h01, 3'h4, h_len[k]});
    end
    groups[1] <= '{8'd20, 8'd22};
    run(2'h1, 1'b1);
    check(rises[15:0], 16'h0001);
    for (int k = 0; k < 3; k++)
    begin
      rdf(8'd20 + k[7:0], FLD_RX);
      check(rd, h_rx[k]);
    end
    rises = 0;
    repeat (40)
    begin
      @(negedge clk);
      if (group_done !== 1'b0) rises++;
    end
    check({rises[14:0], busy}, 16'h0000);
    gpio_dir <= 4'hF;
    gpio_out <= 4'hA;
    repeat (3) @(negedge clk);
    check({12'h0, gpio_in}, 16'h000A);
    master_mode <= 1'b0;
    repeat (4) @(negedge clk);
    check({15'h0, sck_oe}, 16'h0000);
    final_report();
  end
endmodule
`default_nettype wire
